//--- logic/pim_pkg.sv
// constants and types for the interrupt mask block
// assumes an 8-bit register space reached over the serial link
package pim_pkg;
   localparam int unsigned PIM_AW = 8;
   localparam int unsigned PIM_DW = 8;
   typedef logic [PIM_DW-1:0] pim_byte_t;

   localparam pim_byte_t TOP_MASK_ADDR = 8'h20;
   localparam pim_byte_t RST_MASK_ADDR = 8'h21;
   localparam pim_byte_t REG_MASK_ADDR = 8'h22;
   localparam pim_byte_t TOP_FLAG_ADDR = 8'h30;
   localparam pim_byte_t RST_FLAG_ADDR = 8'h31;
   localparam pim_byte_t REG_FLAG_ADDR = 8'h32;
   localparam pim_byte_t LIVE_ADDR     = 8'h33;

   localparam int unsigned TOP_PG_BIT     = 7;
   localparam int unsigned TOP_SYNC_BIT   = 4;
   localparam int unsigned TOP_TW_BIT     = 2;
   localparam int unsigned TOP_MEAS_BIT   = 0;
   localparam int unsigned RST_REG_BIT    = 0;
   localparam int unsigned REG1_LOST_BIT  = 7;
   localparam int unsigned REG1_VALID_BIT = 6;
   localparam int unsigned REG1_ILIM_BIT  = 4;
   localparam int unsigned REG0_LOST_BIT  = 3;
   localparam int unsigned REG0_VALID_BIT = 2;
   localparam int unsigned REG0_ILIM_BIT  = 0;
   localparam int unsigned REG1_PG_FLAG   = 6;
   localparam int unsigned REG0_PG_FLAG   = 2;

   localparam pim_byte_t TOP_FLAG_BITS  = 8'h95;
   localparam pim_byte_t REG_FLAG_BITS  = 8'h55;
   localparam pim_byte_t RST_FLAG_BITS  = 8'h01;
   localparam pim_byte_t REG_MASK_WBITS = 8'hdd;
   localparam pim_byte_t RST_MASK_WBITS = 8'hfe;
   localparam pim_byte_t TOP_MASK_RST   = 8'h95;
   localparam pim_byte_t REG_MASK_RST   = 8'hdd;
   localparam pim_byte_t RST_MASK_RST   = 8'h00;
   localparam pim_byte_t FLAG_RST       = 8'h00;

   typedef struct packed {
      logic [PIM_AW-1:0] addr;
      pim_byte_t         wdata;
      logic              write;
   } pim_link_req_t;

   typedef struct packed {
      logic power_good;
      logic reg1_invalid;
      logic reg1_ilim;
      logic sync_invalid;
      logic reg0_invalid;
      logic thermal_warn;
      logic reg0_ilim;
   } pim_live_t;

   typedef enum logic [1:0] {
      PIM_LK_IDLE = 2'b01,
      PIM_LK_BUSY = 2'b10
   } pim_link_state_t;
endpackage : pim_pkg

//--- logic/pim_irq_mask.sv
// interrupt mask, event flags and request output for the regulator device
// assumes the serial engine hands over one access at a time on link_clk
`timescale 1ns/10ps
module pim_irq_mask (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   input  wire logic                     link_clk,
   input  wire logic                     link_valid,
   input  wire pim_pkg::pim_link_req_t   link_req,
   output logic                          link_ready,
   output pim_pkg::pim_byte_t            link_rdata,
   output logic                          link_rdata_valid,
   input  wire pim_pkg::pim_live_t       live_in,
   input  wire logic                     meas_done,
   input  wire logic                     reg_reset_event,
   input  wire logic                     otp_reset_mask,
   output logic                          irq
);
   import pim_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // link domain
   logic            lrst_s1;
   logic            link_rst_n;
   pim_link_state_t lk_state;
   pim_link_state_t next_lk_state;
   pim_link_req_t   cmd;
   pim_link_req_t   next_cmd;
   logic            req_t;
   logic            next_req_t;
   logic            ack_s1;
   logic            ack_s2;
   logic            ack_q;
   logic            next_link_ready;
   pim_byte_t       next_link_rdata;
   logic            next_link_rdata_valid;
   logic            ack_seen;
   logic            ack_t;
   pim_byte_t       rdata_hold;

   // reset leaves the link domain in step with its own clock
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         lrst_s1    <= 1'b0;
         link_rst_n <= 1'b0;
      end else begin
         lrst_s1    <= 1'b1;
         link_rst_n <= lrst_s1;
      end
   end

   assign ack_seen = ack_s2 ^ ack_q;

   always_comb begin
      next_lk_state         = lk_state;
      next_cmd              = cmd;
      next_req_t            = req_t;
      next_link_ready       = link_ready;
      next_link_rdata       = link_rdata;
      next_link_rdata_valid = 1'b0;
      case (lk_state)
         PIM_LK_IDLE: begin
            if (link_valid && link_ready) begin
               next_cmd        = link_req;
               next_req_t      = ~req_t;
               next_link_ready = 1'b0;
               next_lk_state   = PIM_LK_BUSY;
            end
         end
         PIM_LK_BUSY: begin
            // rdata_hold is stable once the ack toggle has been seen
            if (ack_seen) begin
               next_link_rdata       = rdata_hold;
               next_link_rdata_valid = 1'b1;
               next_link_ready       = 1'b1;
               next_lk_state         = PIM_LK_IDLE;
            end
         end
         default: begin
            next_lk_state   = PIM_LK_IDLE;
            next_link_ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lk_state         <= PIM_LK_IDLE;
         cmd              <= '0;
         req_t            <= 1'b0;
         ack_s1           <= 1'b0;
         ack_s2           <= 1'b0;
         ack_q            <= 1'b0;
         link_ready       <= 1'b1;
         link_rdata       <= FLAG_RST;
         link_rdata_valid <= 1'b0;
      end else begin
         lk_state         <= next_lk_state;
         cmd              <= next_cmd;
         req_t            <= next_req_t;
         ack_s1           <= ack_t;
         ack_s2           <= ack_s1;
         ack_q            <= ack_s2;
         link_ready       <= next_link_ready;
         link_rdata       <= next_link_rdata;
         link_rdata_valid <= next_link_rdata_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // core domain: synchronisers
   pim_live_t live_s1;
   pim_live_t live_s2;
   pim_live_t live_q;
   logic      req_s1;
   logic      req_s2;
   logic      req_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         live_s1 <= '0;
         live_s2 <= '0;
         live_q  <= '0;
         req_s1  <= 1'b0;
         req_s2  <= 1'b0;
         req_q   <= 1'b0;
      end else begin
         live_s1 <= live_in;
         live_s2 <= live_s1;
         live_q  <= live_s2;
         req_s1  <= req_t;
         req_s2  <= req_s1;
         req_q   <= req_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // core domain: registers, flags, request
   pim_byte_t top_mask;
   pim_byte_t next_top_mask;
   pim_byte_t reg_mask;
   pim_byte_t next_reg_mask;
   pim_byte_t rst_mask_hi;
   pim_byte_t next_rst_mask_hi;
   logic      rst_mask_bit;
   logic      next_rst_mask_bit;
   logic      otp_loaded;
   pim_byte_t top_flag;
   pim_byte_t next_top_flag;
   pim_byte_t reg_flag;
   pim_byte_t next_reg_flag;
   logic      rst_flag;
   logic      next_rst_flag;
   pim_byte_t next_rdata_hold;
   logic      next_ack_t;
   logic      next_irq;
   logic      fire;
   logic      do_wr;
   pim_byte_t top_set;
   pim_byte_t reg_set;
   pim_byte_t top_clr;
   pim_byte_t reg_clr;
   logic      rst_clr;
   pim_byte_t reg_gate;
   logic      pending_now;

   assign fire  = req_s2 ^ req_q;
   assign do_wr = fire & cmd.write;

   always_comb begin
      top_set = '0;
      reg_set = '0;
      top_set[TOP_PG_BIT]   = (live_s2.power_good ^ live_q.power_good)
                              & ~top_mask[TOP_PG_BIT];
      top_set[TOP_SYNC_BIT] = live_s2.sync_invalid & ~live_q.sync_invalid
                              & ~top_mask[TOP_SYNC_BIT];
      top_set[TOP_TW_BIT]   = live_s2.thermal_warn & ~live_q.thermal_warn
                              & ~top_mask[TOP_TW_BIT];
      top_set[TOP_MEAS_BIT] = meas_done & ~top_mask[TOP_MEAS_BIT];
      reg_set[REG1_PG_FLAG] =
         (live_s2.reg1_invalid & ~live_q.reg1_invalid & ~reg_mask[REG1_LOST_BIT])
         | (~live_s2.reg1_invalid & live_q.reg1_invalid
            & ~reg_mask[REG1_VALID_BIT]);
      reg_set[REG1_ILIM_BIT] = live_s2.reg1_ilim & ~live_q.reg1_ilim
                               & ~reg_mask[REG1_ILIM_BIT];
      reg_set[REG0_PG_FLAG] =
         (live_s2.reg0_invalid & ~live_q.reg0_invalid & ~reg_mask[REG0_LOST_BIT])
         | (~live_s2.reg0_invalid & live_q.reg0_invalid
            & ~reg_mask[REG0_VALID_BIT]);
      reg_set[REG0_ILIM_BIT] = live_s2.reg0_ilim & ~live_q.reg0_ilim
                               & ~reg_mask[REG0_ILIM_BIT];
   end

   assign top_clr = (do_wr && cmd.addr == TOP_FLAG_ADDR) ? (cmd.wdata & TOP_FLAG_BITS) : '0;
   assign reg_clr = (do_wr && cmd.addr == REG_FLAG_ADDR) ? (cmd.wdata & REG_FLAG_BITS) : '0;
   assign rst_clr = do_wr && cmd.addr == RST_FLAG_ADDR && cmd.wdata[RST_REG_BIT];

   always_comb begin
      reg_gate = '0;
      reg_gate[REG1_PG_FLAG]  = ~(reg_mask[REG1_LOST_BIT] & reg_mask[REG1_VALID_BIT]);
      reg_gate[REG1_ILIM_BIT] = ~reg_mask[REG1_ILIM_BIT];
      reg_gate[REG0_PG_FLAG]  = ~(reg_mask[REG0_LOST_BIT] & reg_mask[REG0_VALID_BIT]);
      reg_gate[REG0_ILIM_BIT] = ~reg_mask[REG0_ILIM_BIT];
   end

   assign pending_now = (|(top_flag & ~top_mask & TOP_FLAG_BITS))
                        | (|(reg_flag & reg_gate)) | (rst_flag & ~rst_mask_bit);

   always_comb begin
      next_top_mask     = top_mask;
      next_reg_mask     = reg_mask;
      next_rst_mask_hi  = rst_mask_hi;
      next_rst_mask_bit = rst_mask_bit;
      next_rdata_hold   = rdata_hold;
      next_ack_t        = ack_t;
      // set wins over a clear landing in the same cycle
      next_top_flag = (top_flag & ~top_clr) | top_set;
      next_reg_flag = (reg_flag & ~reg_clr) | reg_set;
      next_rst_flag = (rst_flag & ~rst_clr)
                      | (reg_reset_event & ~rst_mask_bit);
      // strap caught once at the first edge after reset release
      if (!otp_loaded) begin
         next_rst_mask_bit = otp_reset_mask;
      end
      if (fire) begin
         next_ack_t = ~ack_t;
         case (cmd.addr)
            TOP_MASK_ADDR: next_rdata_hold = top_mask;
            RST_MASK_ADDR: next_rdata_hold = rst_mask_hi | {7'h00, rst_mask_bit};
            REG_MASK_ADDR: next_rdata_hold = reg_mask;
            TOP_FLAG_ADDR: next_rdata_hold = top_flag;
            RST_FLAG_ADDR: next_rdata_hold = {7'h00, rst_flag};
            REG_FLAG_ADDR: next_rdata_hold = reg_flag;
            LIVE_ADDR:     next_rdata_hold = {1'b0, live_s2};
            default:       next_rdata_hold = '0;
         endcase
      end
      if (do_wr) begin
         case (cmd.addr)
            TOP_MASK_ADDR: next_top_mask = cmd.wdata;
            // bit 0 is not writable: the stored memory value stays
            RST_MASK_ADDR: next_rst_mask_hi = cmd.wdata & RST_MASK_WBITS;
            REG_MASK_ADDR: next_reg_mask = cmd.wdata & REG_MASK_WBITS;
            default: ;
         endcase
      end
      next_irq = (|(next_top_flag & ~next_top_mask & TOP_FLAG_BITS))
                 | (next_rst_flag & ~next_rst_mask_bit);
      next_irq = next_irq
                 | (next_reg_flag[REG1_PG_FLAG]
                    & ~(next_reg_mask[REG1_LOST_BIT] & next_reg_mask[REG1_VALID_BIT]))
                 | (next_reg_flag[REG0_PG_FLAG]
                    & ~(next_reg_mask[REG0_LOST_BIT] & next_reg_mask[REG0_VALID_BIT]))
                 | (next_reg_flag[REG1_ILIM_BIT] & ~next_reg_mask[REG1_ILIM_BIT])
                 | (next_reg_flag[REG0_ILIM_BIT] & ~next_reg_mask[REG0_ILIM_BIT]);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         top_mask     <= TOP_MASK_RST;
         reg_mask     <= REG_MASK_RST;
         rst_mask_hi  <= RST_MASK_RST;
         rst_mask_bit <= 1'b1;
         otp_loaded   <= 1'b0;
         top_flag     <= FLAG_RST;
         reg_flag     <= FLAG_RST;
         rst_flag     <= 1'b0;
         rdata_hold   <= FLAG_RST;
         ack_t        <= 1'b0;
         irq          <= 1'b0;
      end else begin
         top_mask     <= next_top_mask;
         reg_mask     <= next_reg_mask;
         rst_mask_hi  <= next_rst_mask_hi;
         rst_mask_bit <= next_rst_mask_bit;
         otp_loaded   <= 1'b1;
         top_flag     <= next_top_flag;
         reg_flag     <= next_reg_flag;
         rst_flag     <= next_rst_flag;
         rdata_hold   <= next_rdata_hold;
         ack_t        <= next_ack_t;
         irq          <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence lk_accept_s;
      link_valid && link_ready;
   endsequence

   // three core edges plus the link-side ack sync: about 36 to 54 link cycles
   sequence lk_answer_s;
      ##[30:60] link_rdata_valid;
   endsequence
   property lk_turn_p;
      @(posedge link_clk) disable iff (!link_rst_n) lk_accept_s |-> lk_answer_s;
   endproperty

   link_turnaround_a: assert property (lk_turn_p)
      else $error("link access not answered in time");
   power_good_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(top_flag[TOP_PG_BIT]) |-> !$past(top_mask[TOP_PG_BIT]))
      else $error("power-good flag set while suppressed");
   live_readback_a: assert property (@(posedge clk) disable iff (!arst_n)
      (fire && !cmd.write && cmd.addr == LIVE_ADDR) |=> rdata_hold == {1'b0, $past(live_s2)})
      else $error("live status read back wrong");
   sync_clk_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(top_flag[TOP_SYNC_BIT]) |-> !$past(top_mask[TOP_SYNC_BIT]))
      else $error("clock flag set while suppressed");
   thermal_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      (live_s2.thermal_warn && !live_q.thermal_warn && !top_mask[TOP_TW_BIT])
      |=> top_flag[TOP_TW_BIT])
      else $error("thermal flag missed");
   meas_done_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      (meas_done && !top_mask[TOP_MEAS_BIT]) |=> top_flag[TOP_MEAS_BIT])
      else $error("measurement flag missed");
   reg_reset_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(rst_flag) |-> !$past(rst_mask_bit))
      else $error("reset flag set while suppressed");
   otp_mask_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      $past(otp_loaded) |-> $stable(rst_mask_bit))
      else $error("reset mask changed after load");
   reg1_lost_set_a: assert property (@(posedge clk) disable iff (!arst_n)
      (live_s2.reg1_invalid && !live_q.reg1_invalid && !reg_mask[REG1_LOST_BIT])
      |=> reg_flag[REG1_PG_FLAG])
      else $error("regulator1 lost flag missed");
   reg1_valid_set_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!live_s2.reg1_invalid && live_q.reg1_invalid && !reg_mask[REG1_VALID_BIT])
      |=> reg_flag[REG1_PG_FLAG])
      else $error("regulator1 valid flag missed");
   reg1_ilim_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(reg_flag[REG1_ILIM_BIT]) |-> !$past(reg_mask[REG1_ILIM_BIT]))
      else $error("regulator1 limit flag set while suppressed");
   reg0_lost_set_a: assert property (@(posedge clk) disable iff (!arst_n)
      (live_s2.reg0_invalid && !live_q.reg0_invalid && !reg_mask[REG0_LOST_BIT])
      |=> reg_flag[REG0_PG_FLAG])
      else $error("regulator0 lost flag missed");
   reg0_valid_set_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!live_s2.reg0_invalid && live_q.reg0_invalid && !reg_mask[REG0_VALID_BIT])
      |=> reg_flag[REG0_PG_FLAG])
      else $error("regulator0 valid flag missed");
   reg0_ilim_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(reg_flag[REG0_ILIM_BIT]) |-> !$past(reg_mask[REG0_ILIM_BIT]))
      else $error("regulator0 limit flag set while suppressed");
   flag_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
      ##1 (($past(top_flag) & ~$past(top_clr) & ~top_flag) == 8'h00))
      else $error("flag dropped without a clear write");
   irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
      irq == pending_now)
      else $error("request does not match pending flags");
endmodule : pim_irq_mask

//--- dv/pim_host_model.sv
// host side model: issues one register access at a time on the serial engine port
// assumes a free running link_clk and one outstanding access at the design
`timescale 1ns/10ps
module pim_host_model (
   input  wire logic                link_clk,
   input  wire logic                link_ready,
   input  wire pim_pkg::pim_byte_t  link_rdata,
   input  wire logic                link_rdata_valid,
   output logic                     link_valid,
   output pim_pkg::pim_link_req_t   link_req
);
   import pim_pkg::*;
   logic slow;

   initial begin
      link_valid = 1'b0;
      link_req   = '0;
      slow       = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // every other access idles three link cycles instead of one, so prompt and late requests both occur
   task automatic access(input pim_byte_t a, input pim_byte_t d, input logic wr,
                         output pim_byte_t rdata);
      int n;
      rdata = 8'hxx;
      slow  = ~slow;
      repeat (slow ? 3 : 1) @(posedge link_clk);
      #1;
      link_valid = 1'b1;
      link_req   = '{addr: a, wdata: d, write: wr};
      n = 0;
      @(posedge link_clk);
      while (link_ready !== 1'b1 && n < 400) begin
         @(posedge link_clk);
         n++;
      end
      #1;
      link_valid = 1'b0;
      // released lines show the inverse, never a stale copy
      link_req   = ~link_req;
      n = 0;
      @(posedge link_clk);
      while (link_rdata_valid !== 1'b1 && n < 400) begin
         @(posedge link_clk);
         n++;
      end
      if (link_rdata_valid === 1'b1) rdata = link_rdata;
   endtask : access
endmodule : pim_host_model

//--- dv/tb.sv
// self-checking bench for the interrupt mask block
// assumes the host model is the only master of the serial engine port
`timescale 1ns/10ps
module tb;
   import pim_pkg::*;
   logic           clk;
   logic           arst_n;
   logic           link_clk;
   logic           link_valid;
   logic           link_ready;
   logic           link_rdata_valid;
   logic           meas_done;
   logic           reg_reset_event;
   logic           otp_reset_mask;
   logic           irq;
   pim_link_req_t  link_req;
   pim_byte_t      link_rdata;
   pim_byte_t      rd;
   pim_live_t      live_in;
   int             errors;
   int             comparisons;

   initial clk = 1'b0;
   always #50 clk = ~clk;
   // link clock offset so its edges drift against the core clock
   initial begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   pim_irq_mask pim_irq_mask_inst (
      .clk              (clk),
      .arst_n           (arst_n),
      .link_clk         (link_clk),
      .link_valid       (link_valid),
      .link_req         (link_req),
      .link_ready       (link_ready),
      .link_rdata       (link_rdata),
      .link_rdata_valid (link_rdata_valid),
      .live_in          (live_in),
      .meas_done        (meas_done),
      .reg_reset_event  (reg_reset_event),
      .otp_reset_mask   (otp_reset_mask),
      .irq              (irq)
   );

   pim_host_model pim_host_model_inst (
      .link_clk         (link_clk),
      .link_ready       (link_ready),
      .link_rdata       (link_rdata),
      .link_rdata_valid (link_rdata_valid),
      .link_valid       (link_valid),
      .link_req         (link_req)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input string nm, input pim_byte_t exp, input pim_byte_t got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk8

   task automatic chk1(input string nm, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", nm, exp, got);
      end
   endtask : chk1

   task automatic wr(input pim_byte_t a, input pim_byte_t d);
      pim_host_model_inst.access(a, d, 1'b1, rd);
      // a timed-out access leaves the returned byte unknown
      if (rd === 8'hxx) begin
         errors++;
         $display("[FAIL] write answer expected old byte seen none");
      end
   endtask : wr

   task automatic rdchk(input string nm, input pim_byte_t a, input pim_byte_t exp);
      pim_host_model_inst.access(a, 8'h00, 1'b0, rd);
      chk8(nm, exp, rd);
   endtask : rdchk

   task automatic apply_reset(input logic otp);
      @(posedge clk);
      #1;
      arst_n         = 1'b0;
      otp_reset_mask = otp;
      repeat (10) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
   endtask : apply_reset

   // src 0..6 is a live pin, 7 measurement done, 8 register reset
   task automatic fire(input int src, input logic lvl);
      @(posedge clk);
      #1;
      if (src == 7) meas_done = 1'b1;
      else if (src == 8) reg_reset_event = 1'b1;
      else live_in[src] = lvl;
      @(posedge clk);
      #1;
      meas_done       = 1'b0;
      reg_reset_event = 1'b0;
   endtask : fire

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values(input logic otp);
      rdchk("top mask", TOP_MASK_ADDR, TOP_MASK_RST);
      rdchk("regulator mask", REG_MASK_ADDR, REG_MASK_RST);
      rdchk("reset mask", RST_MASK_ADDR, RST_MASK_RST | {7'h00, otp});
      rdchk("top flags", TOP_FLAG_ADDR, FLAG_RST);
      chk1("irq idle", 1'b0, irq);
   endtask : t_reset_values

   task automatic t_access;
      wr(TOP_MASK_ADDR, 8'h5a);
      chk8("top old value", TOP_MASK_RST, rd);
      rdchk("top mask rw", TOP_MASK_ADDR, 8'h5a);
      wr(REG_MASK_ADDR, 8'h22);
      rdchk("regulator reserved", REG_MASK_ADDR, 8'h00);
      wr(RST_MASK_ADDR, 8'hff);
      rdchk("reset mask bit0 kept", RST_MASK_ADDR, 8'hfe);
      wr(8'h55, 8'hff);
      rdchk("unmapped", 8'h55, 8'h00);
   endtask : t_access

   // everything suppressed while the pin is prepared, then one mask decides
   task automatic ev_half(input int src, input logic pre, input logic act, input pim_byte_t ma,
                          input int mb, input pim_byte_t fa, input int fb, input logic masked);
      logic expf;
      expf = !masked || (ma == RST_MASK_ADDR);
      wr(TOP_MASK_ADDR, 8'hff);
      wr(REG_MASK_ADDR, 8'hff);
      if (src < 7) fire(src, pre);
      repeat (6) @(posedge clk);
      wr(TOP_FLAG_ADDR, 8'hff);
      wr(RST_FLAG_ADDR, 8'hff);
      wr(REG_FLAG_ADDR, 8'hff);
      wr(ma, masked ? 8'hff : ~(8'h01 << mb));
      fire(src, act);
      repeat (6) @(posedge clk);
      pim_host_model_inst.access(fa, 8'h00, 1'b0, rd);
      chk1("event flag", expf, rd[fb]);
      chk1("irq raised", expf, irq);
      if (masked) begin
         rdchk("live status", LIVE_ADDR, {1'b0, live_in});
      end else begin
         wr(fa, 8'h01 << fb);
         repeat (3) @(posedge clk);
         rdchk("flag cleared", fa, 8'h00);
         chk1("irq released", 1'b0, irq);
      end
   endtask : ev_half

   task automatic ev_row(input int src, input logic pre, input logic act, input pim_byte_t ma,
                         input int mb, input pim_byte_t fa, input int fb);
      ev_half(src, pre, act, ma, mb, fa, fb, 1'b1);
      ev_half(src, pre, act, ma, mb, fa, fb, 1'b0);
   endtask : ev_row

   task automatic t_otp_masked;
      t_reset_values(1'b1);
      wr(RST_MASK_ADDR, 8'h00);
      rdchk("reset mask write ignored", RST_MASK_ADDR, 8'h01);
      wr(RST_FLAG_ADDR, 8'hff);
      fire(8, 1'b1);
      repeat (6) @(posedge clk);
      rdchk("reset flag masked", RST_FLAG_ADDR, 8'h00);
      chk1("irq masked reset", 1'b0, irq);
   endtask : t_otp_masked

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   // 17 accesses per event row at a few core cycles each
   initial begin
      #3_000_000;
      errors++;
      $display("[FAIL] watchdog expected done seen hang");
      close_out();
   end

   initial begin
      arst_n          = 1'b0;
      meas_done       = 1'b0;
      reg_reset_event = 1'b0;
      otp_reset_mask  = 1'b0;
      live_in         = '0;
      errors          = 0;
      comparisons     = 0;
      apply_reset(1'b0);
      t_reset_values(1'b0);
      t_access();
      ev_row(6, 1'b0, 1'b1, TOP_MASK_ADDR, TOP_PG_BIT, TOP_FLAG_ADDR, 7);
      ev_row(3, 1'b0, 1'b1, TOP_MASK_ADDR, TOP_SYNC_BIT, TOP_FLAG_ADDR, 4);
      ev_row(1, 1'b0, 1'b1, TOP_MASK_ADDR, TOP_TW_BIT, TOP_FLAG_ADDR, 2);
      ev_row(7, 1'b0, 1'b1, TOP_MASK_ADDR, TOP_MEAS_BIT, TOP_FLAG_ADDR, 0);
      ev_row(8, 1'b0, 1'b1, RST_MASK_ADDR, RST_REG_BIT, RST_FLAG_ADDR, 0);
      ev_row(5, 1'b0, 1'b1, REG_MASK_ADDR, REG1_LOST_BIT, REG_FLAG_ADDR, REG1_PG_FLAG);
      ev_row(5, 1'b1, 1'b0, REG_MASK_ADDR, REG1_VALID_BIT, REG_FLAG_ADDR, REG1_PG_FLAG);
      ev_row(4, 1'b0, 1'b1, REG_MASK_ADDR, REG1_ILIM_BIT, REG_FLAG_ADDR, 4);
      ev_row(2, 1'b0, 1'b1, REG_MASK_ADDR, REG0_LOST_BIT, REG_FLAG_ADDR, REG0_PG_FLAG);
      ev_row(2, 1'b1, 1'b0, REG_MASK_ADDR, REG0_VALID_BIT, REG_FLAG_ADDR, REG0_PG_FLAG);
      ev_row(0, 1'b0, 1'b1, REG_MASK_ADDR, REG0_ILIM_BIT, REG_FLAG_ADDR, 0);
      apply_reset(1'b1);
      t_otp_masked();
      close_out();
   end
endmodule : tb
